// ---- core/nwt_pkg.sv ----
`default_nettype none
package nwt_pkg;

    // Register offsets, byte addresses in the control space
    localparam logic [11:0] OFS_W2_TBASE  = 12'h008;
    localparam logic [11:0] OFS_W2_SETUP  = 12'h00C;
    localparam logic [11:0] OFS_W3_TBASE  = 12'h010;
    localparam logic [11:0] OFS_W3_SETUP  = 12'h014;

    // Window and port counts and per-bit layout
    localparam int          WIN_COUNT     = 2;
    localparam int          PORT_COUNT    = 2;
    localparam int          TBASE_LSB     = 12;
    localparam int          TBASE_W       = 20;
    localparam int          SIZE_LSB      = 12;
    localparam int          SIZE_W        = 19;
    localparam int          ENABLE_BIT    = 31;
    localparam int          PREF_BIT      = 3;
    localparam int          ATYPE_LSB     = 1;
    localparam int          TYPE_SEL_BIT  = 0;

    // Reset values and field encodings
    localparam logic [19:0] TBASE_RESET   = 20'h00000;
    localparam logic [18:0] SIZE_RESET    = 19'h00000;
    localparam logic [1:0]  ATYPE_32      = 2'h0;
    localparam logic [1:0]  ATYPE_64      = 2'h1;
    localparam logic        TYPE_MEMORY   = 1'h0;
    localparam logic [7:0]  SETUP_RSVD    = 8'h00;
    localparam logic [11:0] TBASE_RSVD    = 12'h000;
    localparam logic [31:0] READ_ZERO     = 32'h00000000;

    // Register selector, one-hot order
    localparam int          SEL_W2_TBASE  = 0;
    localparam int          SEL_W2_SETUP  = 1;
    localparam int          SEL_W3_TBASE  = 2;
    localparam int          SEL_W3_SETUP  = 3;

    typedef struct packed {
        logic        enable;
        logic [18:0] size;
        logic        prefetch;
        logic [1:0]  addrType;
    } nwt_setup_s;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [11:0] addr;
        logic [31:0] wdata;
        logic [3:0]  byteEn;
    } nwt_req_s;

    typedef struct packed {
        logic        ack;
        logic [31:0] rdata;
    } nwt_rsp_s;

    typedef struct packed {
        logic        valid;
        logic        win;
        logic [31:0] addr;
    } nwt_xreq_s;

    typedef struct packed {
        logic        valid;
        logic        hit;
        logic        prefetch;
        logic [1:0]  addrType;
        logic [31:0] addr;
    } nwt_xrsp_s;

    typedef struct packed {
        logic        enable;
        logic        prefetch;
        logic [1:0]  addrType;
        logic [19:0] writeMask;
    } nwt_bar_s;

endpackage
`default_nettype wire

// ---- core/nwt_window.sv ----
`timescale 1ns/1ps
`default_nettype none

module nwt_window (
    input  wire logic               sys_clk,
    input  wire logic               reset,
    input  wire logic [3:0]         tbWrMask,
    input  wire logic [31:0]        tbWrData,
    input  wire logic               initLoad,
    input  wire logic [31:0]        initWord,
    output var  logic [19:0]        tbaseQ,
    output var  nwt_pkg::nwt_setup_s setupQ
);

    // Translated base, one flop per bit, byte-lane write
    genvar b;
    generate
        for (b = 0; b < nwt_pkg::TBASE_W; b++) begin : g_tb
            always_ff @(posedge sys_clk or posedge reset) begin
                if (reset) begin
                    tbaseQ[b] <= 1'h0;
                end else if (tbWrMask[(b + nwt_pkg::TBASE_LSB) / 8]) begin
                    tbaseQ[b] <= tbWrData[b + nwt_pkg::TBASE_LSB];
                end
            end
        end
    endgenerate

    // RL10: init path only
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            setupQ.enable   <= 1'h0;
            setupQ.size     <= nwt_pkg::SIZE_RESET;
            setupQ.prefetch <= 1'h0;
            setupQ.addrType <= nwt_pkg::ATYPE_32;
        end else if (initLoad) begin
            setupQ.enable   <= initWord[nwt_pkg::ENABLE_BIT];
            setupQ.size     <= initWord[nwt_pkg::SIZE_LSB +: nwt_pkg::SIZE_W];
            setupQ.prefetch <= initWord[nwt_pkg::PREF_BIT];
            setupQ.addrType <= initWord[nwt_pkg::ATYPE_LSB +: 2];
        end
    end

endmodule

`default_nettype wire

// ---- core/nwt_addr_xlat.sv ----
`timescale 1ns/1ps
`default_nettype none

module nwt_addr_xlat (
    input  wire logic                addrIn,
    input  wire logic [31:0]         reqAddr,
    input  wire logic [19:0]         tbase,
    input  wire nwt_pkg::nwt_setup_s setup,
    output logic                     hit,
    output logic [31:0]              outAddr
);

    logic [31:0] mask;

    // RL4: sized bits only
    assign mask = {1'h1, setup.size, nwt_pkg::TBASE_RSVD};

    // RL8: disabled window
    assign hit = addrIn & setup.enable;

    // RL9: replace sized bits
    assign outAddr = hit
        ? ((reqAddr & ~mask) | ({tbase, nwt_pkg::TBASE_RSVD} & mask))
        : reqAddr;

endmodule

`default_nettype wire

// ---- core/nwt_window_regs.sv ----
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// RL1: Read and write requests from either the primary or secondary port reach all window registers.
// RL2: Window 2 holds a writable translated base in bits 31:12 that resets to zero.
// RL3: Window 3 holds a writable translated base in bits 31:12 that resets to zero.
// RL4: Only the sized base bits are used, and bits 11:0 of each base read zero.
// RL5: Bit 0 of each setup word always reads zero for memory space.
// RL6: Setup bits 2:1 give 00 for 32-bit or 01 for 64-bit, reset 00, not bus writable.
// RL7: Each setup bit 30:12 at one makes the matching window base bit writable; the code leaves every base bit writable and only drives barCtrl writeMask.
// RL8: Setup bit 31 enables the window, resets to zero so both start disabled.
// RL9: A hit on an enabled window swaps sized bits for base bits and keeps the offset.
// RL10: Setup fields ignore bus writes and load only through the init path.

module nwt_window_regs (
    input  wire logic                  sys_clk,
    input  wire logic                  reset,
    input  wire nwt_pkg::nwt_req_s     priReq,
    input  wire nwt_pkg::nwt_req_s     secReq,
    input  wire logic                  initLoad,
    input  wire logic                  initWin,
    input  wire logic [31:0]           initWord,
    input  wire nwt_pkg::nwt_xreq_s    xlatReq,
    output var  nwt_pkg::nwt_rsp_s     priRsp,
    output var  nwt_pkg::nwt_rsp_s     secRsp,
    output var  nwt_pkg::nwt_xrsp_s    xlatRsp,
    output var  nwt_pkg::nwt_bar_s [1:0] barCtrl
);

    localparam int NP = nwt_pkg::PORT_COUNT;
    localparam int NW = nwt_pkg::WIN_COUNT;

    nwt_pkg::nwt_req_s   req      [NP];
    logic [3:0]          selOne   [NP];
    logic [31:0]         rdWord   [NP];
    nwt_pkg::nwt_rsp_s   rspQ     [NP];

    logic [3:0]          tbMask   [NW][NP];
    logic [3:0]          tbWrMask [NW];
    logic [31:0]         tbWrData [NW];
    logic [19:0]         tbaseQ   [NW];
    nwt_pkg::nwt_setup_s setupQ   [NW];
    logic [NW-1:0]       winInit;

    logic [31:0]         xAddr    [NW];
    logic [NW-1:0]       xHit;
    nwt_pkg::nwt_xrsp_s  xlatD;
    nwt_pkg::nwt_xrsp_s  xlatQ;

    assign req[0] = priReq;
    assign req[1] = secReq;

    // RL5: memory type zero
    function automatic logic [31:0] setupWord(
        input nwt_pkg::nwt_setup_s s
    );
        setupWord = {s.enable, s.size, nwt_pkg::SETUP_RSVD,
                     s.prefetch, s.addrType, nwt_pkg::TYPE_MEMORY};
    endfunction

    // Translated base as seen on a read
    function automatic logic [31:0] tbaseWord(
        input logic [19:0] t
    );
        tbaseWord = {t, nwt_pkg::TBASE_RSVD};
    endfunction

    genvar p;
    genvar w;

    // RL1: decode per port
    generate
        for (p = 0; p < NP; p++) begin : g_port
            always_comb begin
                selOne[p] = 4'h0;
                if (req[p].valid) begin
                    case (req[p].addr)
                        nwt_pkg::OFS_W2_TBASE: begin
                            selOne[p][nwt_pkg::SEL_W2_TBASE] = 1'h1;
                        end
                        nwt_pkg::OFS_W2_SETUP: begin
                            selOne[p][nwt_pkg::SEL_W2_SETUP] = 1'h1;
                        end
                        nwt_pkg::OFS_W3_TBASE: begin
                            selOne[p][nwt_pkg::SEL_W3_TBASE] = 1'h1;
                        end
                        nwt_pkg::OFS_W3_SETUP: begin
                            selOne[p][nwt_pkg::SEL_W3_SETUP] = 1'h1;
                        end
                        default: begin
                            selOne[p] = 4'h0;
                        end
                    endcase
                end
            end

            // RL4: reserved bits read zero
            always_comb begin
                rdWord[p] = nwt_pkg::READ_ZERO;
                if (selOne[p][nwt_pkg::SEL_W2_TBASE]) begin
                    rdWord[p] = tbaseWord(tbaseQ[0]);
                end else if (selOne[p][nwt_pkg::SEL_W2_SETUP]) begin
                    rdWord[p] = setupWord(setupQ[0]);
                end else if (selOne[p][nwt_pkg::SEL_W3_TBASE]) begin
                    rdWord[p] = tbaseWord(tbaseQ[1]);
                end else if (selOne[p][nwt_pkg::SEL_W3_SETUP]) begin
                    rdWord[p] = setupWord(setupQ[1]);
                end
            end

            // Write lanes per window from this port
            always_comb begin
                tbMask[0][p] = 4'h0;
                tbMask[1][p] = 4'h0;
                if (req[p].write) begin
                    if (selOne[p][nwt_pkg::SEL_W2_TBASE]) begin
                        tbMask[0][p] = req[p].byteEn;
                    end
                    if (selOne[p][nwt_pkg::SEL_W3_TBASE]) begin
                        tbMask[1][p] = req[p].byteEn;
                    end
                end
            end

            // Answer one cycle after the request
            always_ff @(posedge sys_clk or posedge reset) begin
                if (reset) begin
                    rspQ[p].ack <= 1'h0;
                end else begin
                    rspQ[p].ack <= req[p].valid;
                end
            end

            // Read data held until next read
            always_ff @(posedge sys_clk or posedge reset) begin
                if (reset) begin
                    rspQ[p].rdata <= nwt_pkg::READ_ZERO;
                end else if (req[p].valid && !req[p].write) begin
                    rspQ[p].rdata <= rdWord[p];
                end
            end
        end
    endgenerate

    assign priRsp = rspQ[0];
    assign secRsp = rspQ[1];

    // Primary port wins a shared byte lane
    generate
        for (w = 0; w < NW; w++) begin : g_merge
            always_comb begin
                tbWrMask[w] = tbMask[w][0] | tbMask[w][1];
                for (int k = 0; k < 4; k++) begin
                    if (tbMask[w][0][k]) begin
                        tbWrData[w][k*8 +: 8] = req[0].wdata[k*8 +: 8];
                    end else begin
                        tbWrData[w][k*8 +: 8] = req[1].wdata[k*8 +: 8];
                    end
                end
            end
        end
    endgenerate

    // RL10: init path selects window
    assign winInit[0] = initLoad & ~initWin;
    assign winInit[1] = initLoad & initWin;

    // RL2: window 2 registers
    nwt_window u_win2 (
        .sys_clk  (sys_clk),
        .reset    (reset),
        .tbWrMask (tbWrMask[0]),
        .tbWrData (tbWrData[0]),
        .initLoad (winInit[0]),
        .initWord (initWord),
        .tbaseQ   (tbaseQ[0]),
        .setupQ   (setupQ[0])
    );

    // RL3: window 3 registers
    nwt_window u_win3 (
        .sys_clk  (sys_clk),
        .reset    (reset),
        .tbWrMask (tbWrMask[1]),
        .tbWrData (tbWrData[1]),
        .initLoad (winInit[1]),
        .initWord (initWord),
        .tbaseQ   (tbaseQ[1]),
        .setupQ   (setupQ[1])
    );

    // RL9: translators per window
    generate
        for (w = 0; w < NW; w++) begin : g_xlat
            nwt_addr_xlat u_xlat (
                .addrIn  (xlatReq.valid),
                .reqAddr (xlatReq.addr),
                .tbase   (tbaseQ[w]),
                .setup   (setupQ[w]),
                .hit     (xHit[w]),
                .outAddr (xAddr[w])
            );

            // RL7: size bits out as writeMask, base bits not gated
            // RL8: enable and attributes out
            assign barCtrl[w] = '{
                enable:    setupQ[w].enable,
                prefetch:  setupQ[w].prefetch,
                addrType:  setupQ[w].addrType,
                writeMask: {1'h1, setupQ[w].size}
            };
        end
    endgenerate

    // RL9: pick window of request
    always_comb begin
        xlatD.valid = xlatReq.valid;
        // RL6: address type reported
        case (xlatReq.win)
            1'h0: begin
                xlatD.hit      = xHit[0];
                xlatD.prefetch = setupQ[0].prefetch;
                xlatD.addrType = setupQ[0].addrType;
                xlatD.addr     = xAddr[0];
            end
            1'h1: begin
                xlatD.hit      = xHit[1];
                xlatD.prefetch = setupQ[1].prefetch;
                xlatD.addrType = setupQ[1].addrType;
                xlatD.addr     = xAddr[1];
            end
            default: begin
                xlatD.hit      = 1'h0;
                xlatD.prefetch = 1'h0;
                xlatD.addrType = nwt_pkg::ATYPE_32;
                xlatD.addr     = xlatReq.addr;
            end
        endcase
    end

    // Translation answer pulse
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            xlatQ.valid <= 1'h0;
        end else begin
            xlatQ.valid <= xlatD.valid;
        end
    end

    // Result held until next request
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            xlatQ.hit      <= 1'h0;
            xlatQ.prefetch <= 1'h0;
            xlatQ.addrType <= nwt_pkg::ATYPE_32;
            xlatQ.addr     <= nwt_pkg::READ_ZERO;
        end else if (xlatD.valid) begin
            xlatQ.hit      <= xlatD.hit;
            xlatQ.prefetch <= xlatD.prefetch;
            xlatQ.addrType <= xlatD.addrType;
            xlatQ.addr     <= xlatD.addr;
        end
    end

    assign xlatRsp = xlatQ;

endmodule

`default_nettype wire

// ---- verification/nwt_regs_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module nwt_regs_sva (
    input wire logic                    sys_clk,
    input wire logic                    reset,
    input wire nwt_pkg::nwt_req_s       priReq,
    input wire nwt_pkg::nwt_req_s       secReq,
    input wire logic                    initLoad,
    input wire logic                    initWin,
    input wire logic [31:0]             initWord,
    input wire nwt_pkg::nwt_xreq_s      xlatReq,
    input wire nwt_pkg::nwt_rsp_s       priRsp,
    input wire nwt_pkg::nwt_rsp_s       secRsp,
    input wire nwt_pkg::nwt_xrsp_s      xlatRsp,
    input wire nwt_pkg::nwt_bar_s [1:0] barCtrl
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    sequence s_load2;
        initLoad && !initWin;
    endsequence
    sequence s_load3;
        initLoad && initWin;
    endsequence
    a_pri_ack: assert property (priReq.valid |=> priRsp.ack)
        else $error("primary ack missing");
    a_sec_ack: assert property (secReq.valid |=> secRsp.ack)
        else $error("secondary ack missing");
    a_ack_cause: assert property (priRsp.ack |-> $past(priReq.valid))
        else $error("primary ack without request");
    a_xlat_valid: assert property (xlatReq.valid |=> xlatRsp.valid)
        else $error("translation answer missing");
    a_win2_load: assert property (s_load2 |=>
        barCtrl[0].enable == $past(initWord[31]) &&
        barCtrl[0].writeMask == {1'h1, $past(initWord[30:12])})
        else $error("window 2 setup not loaded");
    a_win3_type: assert property (s_load3 |=>
        barCtrl[1].addrType == $past(initWord[2:1]) &&
        barCtrl[1].prefetch == $past(initWord[3]))
        else $error("window 3 type not loaded");
    a_setup_hold: assert property (!initLoad |=> $stable(barCtrl))
        else $error("setup changed without init load");
    a_xlat_off: assert property (xlatReq.valid && !initLoad &&
        !barCtrl[xlatReq.win].enable |=> !xlatRsp.hit &&
        xlatRsp.addr == $past(xlatReq.addr))
        else $error("disabled window translated");
    a_rdata_rsvd: assert property (priRsp.ack |->
        priRsp.rdata[0] == 1'h0 && priRsp.rdata[11:4] == 8'h00)
        else $error("reserved read bits not zero");
endmodule
bind nwt_window_regs nwt_regs_sva u_sva (
    .sys_clk(sys_clk), .reset(reset), .priReq(priReq), .secReq(secReq),
    .initLoad(initLoad), .initWin(initWin), .initWord(initWord),
    .xlatReq(xlatReq), .priRsp(priRsp), .secRsp(secRsp),
    .xlatRsp(xlatRsp), .barCtrl(barCtrl)
);
`default_nettype wire

// ---- verification/nwt_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module nwt_host_model (
    input  wire logic              sys_clk,
    input  wire nwt_pkg::nwt_rsp_s rsp,
    output var  nwt_pkg::nwt_req_s req
);
    initial req = '0;
    task automatic access(input logic wr, input logic [11:0] a,
        input logic [31:0] d, input logic [3:0] be,
        output logic ok, output logic [31:0] rd);
        @(posedge sys_clk);
        req <= '{1'h1, wr, a, d, be};
        @(posedge sys_clk);
        req.valid <= 1'h0;
        req.wdata <= ~d;
        #1;
        ok = rsp.ack;
        rd = rsp.rdata;
    endtask
endmodule
`default_nettype wire

// ---- verification/tb_nontransparent_window_translation.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_nontransparent_window_translation;
    logic                    sys_clk;
    logic                    reset;
    logic                    initLoad;
    logic                    initWin;
    logic [31:0]             initWord;
    nwt_pkg::nwt_req_s       priReq;
    nwt_pkg::nwt_req_s       secReq;
    nwt_pkg::nwt_rsp_s       priRsp;
    nwt_pkg::nwt_rsp_s       secRsp;
    nwt_pkg::nwt_xreq_s      xlatReq;
    nwt_pkg::nwt_xrsp_s      xlatRsp;
    nwt_pkg::nwt_bar_s [1:0] barCtrl;
    int                      failCount;
    int                      checkCount;

    nwt_host_model u_pri (.sys_clk(sys_clk), .rsp(priRsp), .req(priReq));
    nwt_host_model u_sec (.sys_clk(sys_clk), .rsp(secRsp), .req(secReq));
    nwt_window_regs u_dut (
        .sys_clk(sys_clk), .reset(reset), .priReq(priReq), .secReq(secReq),
        .initLoad(initLoad), .initWin(initWin), .initWord(initWord),
        .xlatReq(xlatReq), .priRsp(priRsp), .secRsp(secRsp),
        .xlatRsp(xlatRsp), .barCtrl(barCtrl)
    );

    initial begin
        sys_clk = 1'h0;
        forever #20 sys_clk = ~sys_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checkCount++;
        if (seen !== exp) begin
            failCount++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", checkCount, failCount);
        if (failCount == 0 && checkCount > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic wr(input logic s, input logic [11:0] a,
        input logic [31:0] d, input logic [3:0] be);
        logic        ok;
        logic [31:0] v;
        if (s) u_sec.access(1'h1, a, d, be, ok, v);
        else u_pri.access(1'h1, a, d, be, ok, v);
        check({31'h0, ok}, 32'h1);
    endtask

    task automatic rdChk(input logic s, input logic [11:0] a,
        input logic [31:0] exp);
        logic        ok;
        logic [31:0] v;
        if (s) u_sec.access(1'h0, a, 32'h0, 4'hF, ok, v);
        else u_pri.access(1'h0, a, 32'h0, 4'hF, ok, v);
        check({31'h0, ok}, 32'h1);
        check(v, exp);
    endtask

    task automatic load(input logic w, input logic [31:0] word);
        @(posedge sys_clk);
        initLoad <= 1'h1;
        initWin  <= w;
        initWord <= word;
        @(posedge sys_clk);
        initLoad <= 1'h0;
    endtask

    task automatic xlat(input logic w, input logic [31:0] a,
        input logic h, input logic [31:0] exp);
        @(posedge sys_clk);
        xlatReq <= '{1'h1, w, a};
        @(posedge sys_clk);
        xlatReq.valid <= 1'h0;
        #1;
        check({30'h0, xlatRsp.valid, xlatRsp.hit}, {30'h0, 1'h1, h});
        check(xlatRsp.addr, exp);
    endtask

    task automatic doReset;
        @(posedge sys_clk);
        reset <= 1'h1;
        repeat (3) @(posedge sys_clk);
        reset <= 1'h0;
    endtask

    task automatic tResetValues;
        rdChk(1'h0, 12'h008, 32'h0);
        rdChk(1'h1, 12'h00C, 32'h0);
        rdChk(1'h1, 12'h010, 32'h0);
        rdChk(1'h0, 12'h014, 32'h0);
        check({8'h00, barCtrl[0]}, 32'h00080000);
    endtask

    task automatic tBaseAccess;
        wr(1'h0, 12'h008, 32'hFFFFFFFF, 4'hF);
        rdChk(1'h1, 12'h008, 32'hFFFFF000);
        wr(1'h1, 12'h010, 32'h12345678, 4'h6);
        rdChk(1'h0, 12'h010, 32'h00345000);
        fork
            wr(1'h0, 12'h008, 32'hAAAAA000, 4'hF);
            wr(1'h1, 12'h008, 32'h55555000, 4'hC);
        join
        rdChk(1'h0, 12'h008, 32'hAAAAA000);
        wr(1'h0, 12'h304, 32'hFFFFFFFF, 4'hF);
        rdChk(1'h0, 12'h304, 32'h0);
    endtask

    task automatic tSetup;
        wr(1'h0, 12'h00C, 32'hFFFFFFFF, 4'hF);
        wr(1'h1, 12'h014, 32'hFFFFFFFF, 4'hF);
        rdChk(1'h1, 12'h00C, 32'h0);
        rdChk(1'h0, 12'h014, 32'h0);
        load(1'h0, 32'hFFFFFFFF);
        rdChk(1'h0, 12'h00C, 32'hFFFFF00E);
        check({12'h000, barCtrl[0].writeMask}, 32'h000FFFFF);
        load(1'h1, 32'h80000002);
        rdChk(1'h1, 12'h014, 32'h80000002);
        check({8'h00, barCtrl[1]}, 32'h00980000);
    endtask

    task automatic tTranslate;
        wr(1'h0, 12'h010, 32'hABCDE000, 4'hF);
        load(1'h1, 32'hFFFF0008);
        xlat(1'h1, 32'h12345678, 1'h1, 32'hABCD5678);
        check({29'h0, xlatRsp.prefetch, xlatRsp.addrType}, 32'h4);
        load(1'h0, 32'h00000000);
        xlat(1'h0, 32'h12345678, 1'h0, 32'h12345678);
        check({29'h0, xlatRsp.prefetch, xlatRsp.addrType}, 32'h0);
    endtask

    task automatic tSecondReset;
        doReset;
        rdChk(1'h0, 12'h010, 32'h0);
        rdChk(1'h1, 12'h014, 32'h0);
    endtask

    initial begin
        reset    = 1'h1;
        initLoad = 1'h0;
        initWin  = 1'h0;
        initWord = 32'h0;
        xlatReq  = '0;
        repeat (3) @(posedge sys_clk);
        reset <= 1'h0;
        tResetValues;
        tBaseAccess;
        tSetup;
        tTranslate;
        tSecondReset;
        conclude;
    end

    initial begin
        #100000;
        failCount++;
        conclude;
    end
endmodule
`default_nettype wire
